// ---- src/sssm_top.sv ----
// sequencing, power-good and status registers for six supply channels
`timescale 1ns/1ps
module sssm_top
#(
    parameter int CYC_PER_MS = sssm_pkg::MS_CYCLES
)
(
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire sssm_pkg::sssm_req_type req,
    output logic [15:0]               rd_data,
    input  wire logic                 clear_faults,
    input  wire logic [5:0]           start_cmd,
    input  wire logic [5:0]           stop_cmd,
    input  wire logic [5:0]           stop_now_cmd,
    input  wire logic                 control_pin,
    input  wire logic                 control_pin_en,
    input  wire logic                 control_immediate,
    input  wire logic [95:0]          vout_meas,
    input  wire logic [95:0]          uv_fault_level,
    input  wire logic [15:0]          temp_meas,
    input  wire sssm_pkg::sssm_mon_type mon,
    input  wire logic                 temp_fault_flag,
    input  wire logic                 margin_fail,
    input  wire logic                 watchdog_event,
    input  wire logic                 bad_command_flag,
    input  wire logic                 bad_data_flag,
    input  wire logic                 log_full,
    input  wire logic                 log_error,
    output logic [5:0]                supply_enable_out,
    output logic                      power_good_out,
    output logic                      margin_allowed,
    output logic [5:0]                fault_response_req,
    output logic                      alert_out,
    output logic                      ara_respond
);
    // pin crosses into core clock domain
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_d;
    logic       ms_tick;
    logic [17:0] ms_cnt;
    logic [15:0] mode_cfg;
    logic [15:0] overtemp_warning_limit;
    logic [15:0] pg_on  [6];
    logic [15:0] pg_off [6];
    logic [15:0] ton_dly [6];
    logic [15:0] ton_max [6];
    logic [15:0] toff_dly [6];
    logic [15:0] ch_cnt [6];
    sssm_pkg::sssm_ch_type ch_st [6];
    logic [5:0]  ch_was_good;
    logic [7:0]  stat_byte;
    logic [15:8] stat_hi;
    logic [7:0]  stat_volt;
    logic [7:0]  stat_comm;
    logic [7:0]  stat_vend;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_d  <= 1'b0;
        end
        else
        begin
            pin_s1 <= control_pin;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    wire pin_rise = pin_s2 & ~pin_d & control_pin_en;
    wire pin_fall = ~pin_s2 & pin_d & control_pin_en;

    // millisecond enable from core clock
    assign ms_tick = (ms_cnt == 18'(CYC_PER_MS - 1));
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            ms_cnt <= '0;
        else
            ms_cnt <= ms_tick ? '0 : ms_cnt + 18'h00001;
    end

    // command writes; settings are two-byte direct values
    wire wr = req.write;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_cfg      <= sssm_pkg::MODE_RESET;
            overtemp_warning_limit <= sssm_pkg::ZERO16;
        end
        else if (wr && req.cmd == sssm_pkg::CMD_MODE)
            mode_cfg <= req.data;
        else if (wr && req.cmd == sssm_pkg::CMD_TEMP_WARNING_FLAG)
            overtemp_warning_limit <= req.data;
    end

    logic [5:0] ch_good_now;
    logic [5:0] ch_above_off;
    logic [5:0] ch_enabled;
    logic [5:0] ch_ton_fault;
    logic [5:0] ch_pg_fall;
    logic [5:0] ch_uv_mask;
    logic [5:0] ch_off_seq;

    genvar g;
    generate
        for (g = 0; g < sssm_pkg::NUM_CH; g++)
        begin : g_ch
            wire [15:0] v = vout_meas[g*16 +: 16];
            wire [15:0] uv = uv_fault_level[g*16 +: 16];
            wire ch_sel = 1'b1;
            wire cnt_done = (ch_cnt[g] == sssm_pkg::ZERO16);
            wire go  = start_cmd[g] | pin_rise;
            wire now = stop_now_cmd[g] | (pin_fall & control_immediate);
            wire stp = stop_cmd[g] | (pin_fall & ~control_immediate);
            // zero limit disables channel; negative limit is invalid
            assign ch_enabled[g] = (ton_max[g] != sssm_pkg::ZERO16) &&
                                   ton_max[g] < sssm_pkg::TON_MAX_NEG;
            assign ch_good_now[g]  = v > pg_on[g];
            assign ch_above_off[g] = v >= pg_off[g];
            assign ch_uv_mask[g]   = (ch_st[g] == sssm_pkg::CH_TON_WAIT);
            assign ch_off_seq[g]   = ch_enabled[g] &&
                (ch_st[g] == sssm_pkg::CH_TON_WAIT ||
                 ch_st[g] == sssm_pkg::CH_TOFF_WAIT);
            assign ch_ton_fault[g] = (ch_st[g] == sssm_pkg::CH_RAMP) &&
                ms_tick && cnt_done && !(v > uv);
            assign ch_pg_fall[g] = ch_was_good[g] && !ch_above_off[g] &&
                ch_enabled[g];

            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pg_on[g]    <= '0;
                    pg_off[g]   <= '0;
                    ton_dly[g]  <= '0;
                    ton_max[g]  <= '0;
                    toff_dly[g] <= '0;
                end
                else if (wr && ch_sel)
                begin
                    if (req.cmd == sssm_pkg::CMD_PG_ON)
                        pg_on[g] <= req.data;
                    if (req.cmd == sssm_pkg::CMD_PG_OFF)
                        pg_off[g] <= req.data;
                    if (req.cmd == sssm_pkg::CMD_TON_DLY)
                        ton_dly[g] <= req.data;
                    if (req.cmd == sssm_pkg::CMD_TON_MAX)
                        ton_max[g] <= req.data;
                    if (req.cmd == sssm_pkg::CMD_TOFF_DLY)
                        toff_dly[g] <= req.data;
                end
            end

            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    ch_st[g]  <= sssm_pkg::CH_OFF;
                    ch_cnt[g] <= '0;
                    supply_enable_out[g] <= 1'b0;
                    ch_was_good[g] <= 1'b0;
                end
                else
                begin
                    if (ch_good_now[g])
                        ch_was_good[g] <= 1'b1;
                    else if (!ch_above_off[g] || !ch_enabled[g])
                        ch_was_good[g] <= 1'b0;
                    if (!ch_enabled[g] || now)
                    begin
                        ch_st[g] <= sssm_pkg::CH_OFF;
                        supply_enable_out[g] <= 1'b0;
                    end
                    else
                    case (ch_st[g])
                    sssm_pkg::CH_OFF:
                        if (go)
                        begin
                            ch_st[g]  <= sssm_pkg::CH_TON_WAIT;
                            ch_cnt[g] <= ton_dly[g];
                        end
                    sssm_pkg::CH_TON_WAIT:
                        if (ms_tick && cnt_done)
                        begin
                            ch_st[g] <= sssm_pkg::CH_RAMP;
                            ch_cnt[g] <= ton_max[g];
                            supply_enable_out[g] <= 1'b1;
                        end
                        else if (ms_tick)
                            ch_cnt[g] <= ch_cnt[g] - 16'h0001;
                    sssm_pkg::CH_RAMP:
                        if (v > uv)
                            ch_st[g] <= sssm_pkg::CH_ON;
                        else if (ch_ton_fault[g])
                        begin
                            ch_st[g] <= sssm_pkg::CH_OFF;
                            supply_enable_out[g] <= 1'b0;
                        end
                        else if (ms_tick)
                            ch_cnt[g] <= ch_cnt[g] - 16'h0001;
                    sssm_pkg::CH_ON:
                        if (stp)
                        begin
                            ch_st[g]  <= sssm_pkg::CH_TOFF_WAIT;
                            ch_cnt[g] <= toff_dly[g];
                        end
                    sssm_pkg::CH_TOFF_WAIT:
                        if (ms_tick && cnt_done)
                        begin
                            ch_st[g] <= sssm_pkg::CH_OFF;
                            supply_enable_out[g] <= 1'b0;
                        end
                        else if (ms_tick)
                            ch_cnt[g] <= ch_cnt[g] - 16'h0001;
                    default:
                        ch_st[g] <= sssm_pkg::CH_OFF;
                    endcase
                end
            end
        end
    endgenerate

    wire all_good = &(ch_good_now | ~ch_enabled) && |ch_enabled;
    wire any_low  = |(~ch_above_off & ch_enabled);
    assign margin_allowed = all_good;
    assign fault_response_req = ch_ton_fault;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            power_good_out <= 1'b0;
        else if (any_low)
            power_good_out <= 1'b0;
        else if (all_good)
            power_good_out <= 1'b1;
    end

    // sticky event sources; set wins over clear
    wire ev_temp_warn = $signed(temp_meas) > $signed(overtemp_warning_limit);
    wire [5:0] uv_f = {6{mon.uv_fault}} & ~ch_uv_mask;
    wire [5:0] uv_w = {6{mon.uv_warn}} & ~ch_uv_mask;
    wire ev_uvf = |uv_f;
    wire ev_uvw = |uv_w;
    wire ev_ton = |ch_ton_fault;
    wire ev_pgf = |ch_pg_fall;
    wire ev_off = |ch_off_seq | ev_ton;

    logic [7:0] set_volt;
    logic [7:0] set_vend;
    logic [7:0] set_comm;
    logic [7:0] set_byte;
    always_comb
    begin
        set_volt = '0;
        set_volt[sssm_pkg::SV_OVF] = mon.ov_fault;
        set_volt[sssm_pkg::SV_OVW] = mon.ov_warn;
        set_volt[sssm_pkg::SV_UVW] = ev_uvw;
        set_volt[sssm_pkg::SV_UVF] = ev_uvf;
        set_volt[sssm_pkg::SV_TON] = ev_ton;
        set_vend = '0;
        set_vend[sssm_pkg::SM_OFF] = ev_off;
        set_vend[sssm_pkg::SM_OTW] = ev_temp_warn;
        set_vend[sssm_pkg::SM_OTF] = temp_fault_flag;
        set_vend[sssm_pkg::SM_WDG] = watchdog_event;
        set_vend[sssm_pkg::SM_MRG] = margin_fail;
        set_vend[sssm_pkg::SM_PGF] = ev_pgf;
        set_vend[sssm_pkg::SM_OCF] = mon.overcurrent_fault_flag;
        set_vend[sssm_pkg::SM_OCW] = mon.overcurrent_warning_flag;
        set_comm = '0;
        set_comm[sssm_pkg::SC_CMD]  = bad_command_flag;
        set_comm[sssm_pkg::SC_DATA] = bad_data_flag;
        set_comm[sssm_pkg::SC_LOG]  = log_full;
        set_byte = '0;
        set_byte[sssm_pkg::SB_OV]   = mon.ov_fault;
        set_byte[sssm_pkg::SB_OC]   = mon.overcurrent_fault_flag;
        set_byte[sssm_pkg::SB_TEMP] = ev_temp_warn | temp_fault_flag;
        set_byte[sssm_pkg::SB_CML]  = |set_comm | log_error;
        set_byte[sssm_pkg::SB_CA]   = ev_ton | ev_pgf | ev_uvf | ev_uvw |
            mon.ov_warn | mon.overcurrent_warning_flag;
    end

    // status registers are read-only and hold until clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stat_byte <= '0;
            stat_volt <= '0;
            stat_comm <= '0;
            stat_vend <= '0;
            stat_hi   <= '0;
        end
        else
        begin
            stat_byte <= (clear_faults ? 8'h00 : stat_byte) | set_byte;
            stat_volt <= (clear_faults ? 8'h00 : stat_volt) | set_volt;
            stat_comm <= (clear_faults ? 8'h00 : stat_comm) | set_comm;
            stat_vend <= (clear_faults ? 8'h00 : stat_vend) | set_vend;
            stat_hi[sssm_pkg::SW_VOUT] <= (~clear_faults &
                stat_hi[sssm_pkg::SW_VOUT]) | (|set_volt);
            stat_hi[sssm_pkg::SW_IOUT] <= (~clear_faults &
                stat_hi[sssm_pkg::SW_IOUT]) | mon.overcurrent_fault_flag | mon.overcurrent_warning_flag;
            stat_hi[sssm_pkg::SW_MFR] <= (~clear_faults &
                stat_hi[sssm_pkg::SW_MFR]) | (|set_vend);
            stat_hi[sssm_pkg::SW_PGF] <= (~clear_faults &
                stat_hi[sssm_pkg::SW_PGF]) | ev_pgf;
            stat_hi[13] <= 1'b0;
            stat_hi[10:8] <= 3'h0;
        end
    end

    // alert: off and pg-failed bits are excluded
    wire alert_src = |(stat_volt) | |stat_comm | stat_byte[sssm_pkg::SB_CML] |
        |(stat_vend & 8'h7B);
    wire alert_en = mode_cfg[sssm_pkg::MODE_ALERT_BIT];
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            alert_out   <= 1'b0;
            ara_respond <= 1'b0;
        end
        else
        begin
            alert_out   <= alert_en & alert_src;
            ara_respond <= alert_en & alert_src;
        end
    end

    // read path, one cycle after request
    logic [15:0] next_rd;
    always_comb
    begin
        if (req.cmd == sssm_pkg::CMD_STAT_BYTE)
            next_rd = {8'h00, stat_byte};
        else if (req.cmd == sssm_pkg::CMD_STAT_WORD)
            next_rd = {stat_hi, stat_byte};
        else if (req.cmd == sssm_pkg::CMD_STAT_VOLT)
            next_rd = {8'h00, stat_volt};
        else if (req.cmd == sssm_pkg::CMD_STAT_COMM)
            next_rd = {8'h00, stat_comm};
        else if (req.cmd == sssm_pkg::CMD_STAT_VEND)
            next_rd = {8'h00, stat_vend};
        else if (req.cmd == sssm_pkg::CMD_TEMP_WARNING_FLAG)
            next_rd = overtemp_warning_limit;
        else if (req.cmd == sssm_pkg::CMD_MODE)
            next_rd = mode_cfg;
        else if (req.cmd == sssm_pkg::CMD_TON_MAX)
            next_rd = ton_max[0];
        else if (req.cmd == sssm_pkg::CMD_PG_ON)
            next_rd = pg_on[0];
        else if (req.cmd == sssm_pkg::CMD_PG_OFF)
            next_rd = pg_off[0];
        else if (req.cmd == sssm_pkg::CMD_TON_DLY)
            next_rd = ton_dly[0];
        else if (req.cmd == sssm_pkg::CMD_TOFF_DLY)
            next_rd = toff_dly[0];
        else
            next_rd = 16'h0000;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data <= '0;
        else if (req.read)
            rd_data <= next_rd;
    end

    property p_pg_drop;
        @(posedge core_clk) disable iff (!arst_n)
        any_low |=> !power_good_out;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("pg not dropped");

    property p_pg_rise;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(power_good_out) |-> $past(all_good);
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("pg early");

    property p_sticky;
        @(posedge core_clk) disable iff (!arst_n)
        (stat_byte[0] && !clear_faults) |=> stat_byte[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("bit lost");

    property p_ton;
        @(posedge core_clk) disable iff (!arst_n)
        ev_ton |=> stat_volt[sssm_pkg::SV_TON] && stat_byte[0] && stat_hi[15];
    endproperty
    a_ton: assert property (p_ton) else $error("ton bits");

    property p_zero;
        @(posedge core_clk) disable iff (!arst_n)
        stat_byte[7:6] == 2'b00 && stat_byte[3] == 1'b0 && stat_hi[13] == 1'b0;
    endproperty
    a_zero: assert property (p_zero) else $error("reserved set");

    property p_alert;
        @(posedge core_clk) disable iff (!arst_n)
        !alert_en |=> !alert_out;
    endproperty
    a_alert: assert property (p_alert) else $error("alert gated");

    property p_pgf;
        @(posedge core_clk) disable iff (!arst_n)
        ev_pgf |=> stat_vend[sssm_pkg::SM_PGF] && stat_hi[11] && stat_hi[12];
    endproperty
    a_pgf: assert property (p_pgf) else $error("pg fail bits");

    property p_now;
        @(posedge core_clk) disable iff (!arst_n)
        stop_now_cmd[0] |=> !supply_enable_out[0];
    endproperty
    a_now: assert property (p_now) else $error("immediate off");
endmodule

// ---- common/sssm_pkg.sv ----
// constants and carrier types for the supply sequencing status monitor
package sssm_pkg;
    localparam int          NUM_CH        = 6;
    localparam logic [7:0]  CMD_TEMP_WARNING_FLAG   = 8'h51;
    localparam logic [7:0]  CMD_PG_ON     = 8'h5E;
    localparam logic [7:0]  CMD_PG_OFF    = 8'h5F;
    localparam logic [7:0]  CMD_TON_DLY   = 8'h60;
    localparam logic [7:0]  CMD_TON_MAX   = 8'h62;
    localparam logic [7:0]  CMD_TOFF_DLY  = 8'h64;
    localparam logic [7:0]  CMD_STAT_BYTE = 8'h78;
    localparam logic [7:0]  CMD_STAT_WORD = 8'h79;
    localparam logic [7:0]  CMD_STAT_VOLT = 8'h7A;
    localparam logic [7:0]  CMD_STAT_COMM = 8'h7E;
    localparam logic [7:0]  CMD_STAT_VEND = 8'h80;
    localparam logic [7:0]  CMD_MODE      = 8'hD1;
    localparam int          MODE_ALERT_BIT = 13;
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    localparam logic [15:0] TON_MAX_NEG   = 16'h8000;
    localparam logic [15:0] ZERO16        = 16'h0000;
    localparam int          CLK_MHZ       = 250;
    localparam int          MS_TIME       = 1;
    localparam int          MS_CYCLES     = MS_TIME * CLK_MHZ * 1000;
    // bit positions
    localparam int SB_OV = 5, SB_OC = 4, SB_TEMP = 2, SB_CML = 1, SB_CA = 0;
    localparam int SW_VOUT = 15, SW_IOUT = 14, SW_MFR = 12, SW_PGF = 11;
    localparam int SV_OVF = 7, SV_OVW = 6, SV_UVW = 5, SV_UVF = 4, SV_TON = 2;
    localparam int SC_CMD = 7, SC_DATA = 6, SC_LOG = 0;
    localparam int SM_OFF = 7, SM_OTW = 6, SM_OTF = 5, SM_WDG = 4;
    localparam int SM_MRG = 3, SM_PGF = 2, SM_OCF = 1, SM_OCW = 0;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  cmd;
        logic [15:0] data;
    } sssm_req_type;

    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
        logic overcurrent_fault_flag;
        logic overcurrent_warning_flag;
    } sssm_mon_type;

    typedef enum logic [2:0] {
        CH_OFF, CH_TON_WAIT, CH_RAMP, CH_ON, CH_TOFF_WAIT
    } sssm_ch_type;
endpackage

// ---- tb/sssm_supply_model.sv ----
// behavioural model of the six controlled supplies
`timescale 1ns/1ps
module sssm_supply_model
(
    input  wire logic        core_clk,
    input  wire logic [95:0] vout_set,
    output logic      [95:0] vout_meas
);
    // measurement lags the supply by one sample, as an adc would
    always_ff @(posedge core_clk)
    begin
        vout_meas <= vout_set;
    end
endmodule

// ---- tb/test_supply_sequencing_status_monitor.sv ----
// self-checking testbench for the supply sequencing status monitor
`timescale 1ns/1ps
module test_supply_sequencing_status_monitor;
    logic                   core_clk;
    logic                   arst_n;
    sssm_pkg::sssm_req_type req;
    logic [15:0]            rd_data;
    logic                   clear_faults;
    logic [5:0]             start_cmd;
    logic [5:0]             stop_cmd;
    logic [5:0]             stop_now_cmd;
    logic                   ara_respond;
    logic [95:0]            vout_meas;
    logic [95:0]            vout_set;
    logic [15:0]            temp_meas;
    sssm_pkg::sssm_mon_type mon;
    logic [6:0]             ev;
    logic [5:0]             supply_enable_out;
    logic                   power_good_out;
    logic                   margin_allowed;
    logic                   alert_out;
    int                     errors;
    int                     checks;
    logic [7:0]             cmds [6];
    logic [15:0]            vals [6];
    // short millisecond so sequencing fits the run
    localparam int          MS = 20;

    sssm_supply_model i_sssm_supply_model
    (
        .core_clk (core_clk),
        .vout_set (vout_set),
        .vout_meas(vout_meas)
    );

    sssm_top #(.CYC_PER_MS(MS)) i_sssm_top
    (
        .core_clk(core_clk), .arst_n(arst_n), .req(req),
        .rd_data(rd_data), .clear_faults(clear_faults),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .stop_now_cmd(stop_now_cmd),
        .control_pin(1'b0), .control_pin_en(1'b0),
        .control_immediate(1'b0), .vout_meas(vout_meas),
        .uv_fault_level({6{16'h0040}}), .temp_meas(temp_meas),
        .mon(mon), .temp_fault_flag(ev[6]), .margin_fail(ev[5]),
        .watchdog_event(ev[4]), .bad_command_flag(ev[3]),
        .bad_data_flag(ev[2]), .log_full(ev[1]), .log_error(ev[0]),
        .supply_enable_out(supply_enable_out),
        .power_good_out(power_good_out),
        .margin_allowed(margin_allowed), .fault_response_req(),
        .alert_out(alert_out), .ara_respond(ara_respond)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, cmd, data};
        @(posedge core_clk);
        req <= '0;
    endtask

    task automatic rdc(input logic [7:0] cmd, input logic [15:0] mask,
                       input logic [15:0] exp);
        @(posedge core_clk);
        req <= '{1'b0, 1'b1, cmd, 16'h0000};
        @(posedge core_clk);
        req <= '0;
        #1;
        check(rd_data & mask, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse_clear;
        @(posedge core_clk);
        clear_faults <= 1'b1;
        @(posedge core_clk);
        clear_faults <= 1'b0;
    endtask

    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        test_done();
    end

    initial
    begin
        errors = 0;
        checks = 0;
        arst_n = 1'b0;
        req = '0;
        clear_faults = 1'b0;
        start_cmd = 6'h00;
        stop_cmd = 6'h00;
        stop_now_cmd = 6'h00;
        vout_set = '0;
        // not above the zero limit that reset leaves
        temp_meas = 16'h0000;
        mon = '0;
        ev = '0;
        // turn-on limit kept above five milliseconds
        cmds = '{8'h51, 8'h5E, 8'h5F, 8'h60, 8'h62, 8'h64};
        vals = '{16'h0050, 16'h0100, 16'h0080, 16'h0003, 16'h000A,
                 16'h0002};
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc(sssm_pkg::CMD_STAT_WORD, 16'hFFFF, 16'h0000);
        for (int i = 0; i < 6; i++)
            wr(cmds[i], vals[i]);
        for (int i = 0; i < 6; i++)
            rdc(cmds[i], 16'hFFFF, vals[i]);
        wr(8'h33, 16'h1234);
        rdc(8'h33, 16'hFFFF, 16'h0000);
        wr(sssm_pkg::CMD_STAT_BYTE, 16'h00FF);
        rdc(sssm_pkg::CMD_STAT_BYTE, 16'hFFFF, 16'h0000);
        wr(sssm_pkg::CMD_MODE, 16'h2000);
        // one channel still below its on level holds power good off
        @(posedge core_clk);
        vout_set <= {16'h00C0, {5{16'h0200}}};
        settle(6);
        check(power_good_out, 1'b0);
        check(margin_allowed, 1'b0);
        @(posedge core_clk);
        vout_set <= {6{16'h0200}};
        settle(6);
        check(power_good_out, 1'b1);
        check(margin_allowed, 1'b1);
        // between the two levels is hysteresis, not a failure
        @(posedge core_clk);
        vout_set[15:0] <= 16'h00C0;
        settle(6);
        check(power_good_out, 1'b1);
        @(posedge core_clk);
        vout_set[63:48] <= 16'h0040;
        settle(6);
        check(power_good_out, 1'b0);
        check(alert_out, 1'b0);
        @(posedge core_clk);
        vout_set <= {6{16'h0200}};
        settle(6);
        rdc(sssm_pkg::CMD_STAT_BYTE, 16'hFFFF, 16'h0001);
        rdc(sssm_pkg::CMD_STAT_WORD, 16'h1801, 16'h1801);
        rdc(sssm_pkg::CMD_STAT_VEND, 16'h007F, 16'h0004);
        pulse_clear();
        rdc(sssm_pkg::CMD_STAT_BYTE, 16'hFFFF, 16'h0000);
        @(posedge core_clk);
        temp_meas <= 16'h0060;
        settle(4);
        check(alert_out, 1'b1);
        check(ara_respond, 1'b1);
        rdc(sssm_pkg::CMD_STAT_BYTE, 16'hFFFF, 16'h0004);
        rdc(sssm_pkg::CMD_STAT_WORD, 16'hF7FF, 16'h1004);
        rdc(sssm_pkg::CMD_STAT_VEND, 16'h007F, 16'h0040);
        @(posedge core_clk);
        temp_meas <= 16'h0020;
        wr(sssm_pkg::CMD_MODE, 16'h0000);
        pulse_clear();
        @(posedge core_clk);
        temp_meas <= 16'h0060;
        mon <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        ev <= 7'h7F;
        @(posedge core_clk);
        mon <= '0;
        ev <= 7'h00;
        settle(4);
        check(alert_out, 1'b0);
        check(ara_respond, 1'b0);
        rdc(sssm_pkg::CMD_STAT_BYTE, 16'hFFFF, 16'h0037);
        rdc(sssm_pkg::CMD_STAT_WORD, 16'hFFFF, 16'hD037);
        rdc(sssm_pkg::CMD_STAT_VOLT, 16'hFFFF, 16'h00C0);
        rdc(sssm_pkg::CMD_STAT_COMM, 16'hFFFF, 16'h00C1);
        rdc(sssm_pkg::CMD_STAT_VEND, 16'h007F, 16'h007B);
        // a zero limit keeps every channel off after a start
        wr(sssm_pkg::CMD_TON_MAX, 16'h0000);
        @(posedge core_clk);
        start_cmd <= 6'h3F;
        @(posedge core_clk);
        start_cmd <= 6'h00;
        settle(5 * MS);
        check({10'h000, supply_enable_out}, 16'h0000);
        // all channels wait together, so a low-voltage pulse is masked
        pulse_clear();
        wr(sssm_pkg::CMD_TON_MAX, 16'h000A);
        @(posedge core_clk);
        vout_set <= '0;
        start_cmd <= 6'h3F;
        @(posedge core_clk);
        start_cmd <= 6'h00;
        mon <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        @(posedge core_clk);
        mon <= '0;
        settle(3 * MS - 2);
        check({10'h000, supply_enable_out}, 16'h0000);
        settle(MS + 2);
        check({10'h000, supply_enable_out}, 16'h003F);
        // supplies never reach the undervoltage level: timeout
        settle(10 * MS - 2);
        check({10'h000, supply_enable_out}, 16'h003F);
        settle(MS + 4);
        check({10'h000, supply_enable_out}, 16'h0000);
        rdc(sssm_pkg::CMD_STAT_VOLT, 16'h0030, 16'h0000);
        rdc(sssm_pkg::CMD_STAT_VOLT, 16'hFFFF, 16'h0004);
        rdc(sssm_pkg::CMD_STAT_WORD, 16'h8001, 16'h8001);
        // supplies come up; one soft stop, one immediate stop
        @(posedge core_clk);
        vout_set <= {6{16'h0200}};
        start_cmd <= 6'h3F;
        @(posedge core_clk);
        start_cmd <= 6'h00;
        settle(4 * MS + 2);
        check({10'h000, supply_enable_out}, 16'h003F);
        @(posedge core_clk);
        stop_cmd <= 6'h02;
        stop_now_cmd <= 6'h01;
        @(posedge core_clk);
        stop_cmd <= 6'h00;
        stop_now_cmd <= 6'h00;
        settle(1);
        check({10'h000, supply_enable_out}, 16'h003E);
        settle(2 * MS - 1);
        check({10'h000, supply_enable_out}, 16'h003E);
        settle(MS + 1);
        check({10'h000, supply_enable_out}, 16'h003C);
        test_done();
    end
endmodule
